// *** core/hscb_pkg.sv ***
// shared types and constants for the fast pulse counter bank
package hscb_pkg;
   localparam int NCH     = 4;
   localparam int CNT_W   = 32;
   localparam int CPR_W   = 28;
   localparam int MODE_W  = 4;
   localparam int NGATE   = 3;
   localparam int GATE_W  = 20;
   localparam int CLK_NS  = 50;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int DIV_W   = 5;
   localparam int GATE_1S_MS   = 1000;
   localparam int GATE_100MS_MS = 100;
   localparam int GATE_10MS_MS  = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int QUAD_CH = 0;
   localparam int MARK_CH = 2;

   localparam logic [CNT_W-1:0] ONE = 32'h1;

   typedef enum logic [2:0] {
      TY_OFF   = 3'h0,
      TY_FREQ  = 3'h1,
      TY_TOTAL = 3'h2,
      TY_PULSE = 3'h3,
      TY_QUAD  = 3'h4,
      TY_MARK  = 3'h5
   } hscb_type_t;

   // mode codes, meaning depends on type
   localparam logic [MODE_W-1:0] FRQ_1S    = 4'h0;
   localparam logic [MODE_W-1:0] FRQ_100MS = 4'h1;
   localparam logic [MODE_W-1:0] FRQ_10MS  = 4'h2;
   localparam logic [MODE_W-1:0] FRQ_SCAN  = 4'h3;
   localparam logic [MODE_W-1:0] TOT_RISE  = 4'h0;
   localparam logic [MODE_W-1:0] TOT_FALL  = 4'h1;
   localparam logic [MODE_W-1:0] PUL_HIGH  = 4'h0;
   localparam logic [MODE_W-1:0] PUL_LOW   = 4'h1;
   localparam logic [MODE_W-1:0] PUL_PRISE = 4'h2;
   localparam logic [MODE_W-1:0] PUL_PFALL = 4'h3;
   localparam logic [MODE_W-1:0] QUAD_UP   = 4'h0;
   localparam logic [MODE_W-1:0] QUAD_DN   = 4'h1;
   localparam logic [1:0] MK_Q_NONE = 2'h0;
   localparam logic [1:0] MK_Q_PH1  = 2'h1;
   localparam logic [1:0] MK_Q_PH2  = 2'h2;
   localparam logic [1:0] MK_RISE   = 2'h0;
   localparam logic [1:0] MK_FALL   = 2'h1;
   localparam logic [1:0] MK_BOTH   = 2'h2;

   // marker mode layout
   typedef struct packed {
      logic [1:0] qual;
      logic       phFall;
      logic       lvlHigh;
   } hscb_mkmode_t;

   typedef struct packed {
      hscb_type_t              kind;
      logic [MODE_W-1:0]       mode;
      logic [CPR_W-1:0]        cpr;
   } hscb_cfg_t;

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } hscb_pin_t;

   typedef enum logic [1:0] {
      PS_ARM = 2'b01,
      PS_RUN = 2'b10
   } hscb_pstate_t;

   typedef struct packed {
      logic [NCH-1:0][CNT_W-1:0] cnt;
      logic [NCH-1:0][CNT_W-1:0] acc;
      hscb_pstate_t [NCH-1:0]    ps;
      logic [NCH-1:0]            img;
      logic                      markRej;
   } hscb_state_t;

   typedef struct packed {
      logic [DIV_W-1:0]              div;
      logic                          tick;
      logic [NGATE-1:0][GATE_W-1:0]  gcnt;
      logic [NGATE-1:0]              gate;
   } hscb_tb_t;

   typedef struct packed {
      logic lvl;
   } hscb_pcs_t;

   localparam hscb_state_t ST_RST = '{cnt: '0, acc: '0,
      ps: '{default: PS_ARM}, img: '0, markRej: 1'b0};
   localparam hscb_tb_t TB_RST = '0;
   localparam hscb_pcs_t PCS_RST = '0;
endpackage

// *** core/hscb_pin_cond.sv ***
// input polarity and edge detection for one field input
`timescale 1ns/1ps
module hscb_pin_cond (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // field side
   input  wire logic               pinRaw,
   input  wire logic               activeLow,
   // conditioned level and edges
   output hscb_pkg::hscb_pin_t     pin
);
   hscb_pkg::hscb_pcs_t st_q;
   hscb_pkg::hscb_pcs_t st_d;
   logic                lvl;

   // inputs arrive synchronous, so one stage of history suffices
   always_comb begin
      lvl       = pinRaw ^ activeLow;
      st_d      = st_q;
      st_d.lvl  = lvl;
      pin.level = lvl;
      pin.rise  = lvl & ~st_q.lvl;
      pin.fall  = ~lvl & st_q.lvl;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_q <= hscb_pkg::PCS_RST;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// *** core/hscb_timebase.sv ***
// 1 us tick and frequency gate pulses
`timescale 1ns/1ps
module hscb_timebase #(
   parameter int TICK_CYC = hscb_pkg::TICK_CYC,
   parameter int G0_TICKS = 1000000,
   parameter int G1_TICKS = 100000,
   parameter int G2_TICKS = 10000
) (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // timing pulses
   output logic                           tick,
   output logic [hscb_pkg::NGATE-1:0]     gate
);
   localparam int DW = hscb_pkg::DIV_W;
   localparam int GW = hscb_pkg::GATE_W;
   localparam int GL [hscb_pkg::NGATE] = '{G0_TICKS, G1_TICKS, G2_TICKS};

   hscb_pkg::hscb_tb_t st_q;
   hscb_pkg::hscb_tb_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      st_d.gate = '0;
      if (st_q.div == DW'(TICK_CYC - 1)) begin
         st_d.div  = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.div = DW'(st_q.div + 1'b1);
      end
      for (int i = 0; i < hscb_pkg::NGATE; i++) begin
         if (st_q.tick) begin
            if (st_q.gcnt[i] == GW'(GL[i] - 1)) begin
               st_d.gcnt[i] = '0;
               st_d.gate[i] = 1'b1;
            end else begin
               st_d.gcnt[i] = GW'(st_q.gcnt[i] + 1'b1);
            end
         end
      end
      tick = st_q.tick;
      gate = st_q.gate;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_q <= hscb_pkg::TB_RST;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// *** core/hscb_counter_bank.sv ***
// bank of four fast pulse counters with marker reset
`timescale 1ns/1ps
// Notes on behaviour
// - There are four counter channels, each with its own type, mode and limit.
// - A polarity input selects whether a high or a low input level is asserted.
// - Each channel type is off, frequency, totalize, pulse, quadrature or marker.
// - An off channel reports its input in the image bit and does not count.
// - Frequency counts rising edges over a 1 s, 100 ms, 10 ms or scan gate.
// - Totalize counts rising or falling edges as the mode selects.
// - Pulse type times high width, low width or either period in 1 us ticks.
// - Quadrature decodes two phases and the mode chooses the count direction.
// - Marker is legal only on channel three while channel one is quadrature.
// - A selected marker edge, or a selected phase edge while the marker is at a set level, clears the quadrature count.
// - The limit is ignored for every type except totalize and quadrature.
module hscb_counter_bank #(
   parameter int G0_TICKS = hscb_pkg::GATE_1S_MS
                            * (hscb_pkg::NS_PER_MS / hscb_pkg::TICK_NS),
   parameter int G1_TICKS = hscb_pkg::GATE_100MS_MS
                            * (hscb_pkg::NS_PER_MS / hscb_pkg::TICK_NS),
   parameter int G2_TICKS = hscb_pkg::GATE_10MS_MS
                            * (hscb_pkg::NS_PER_MS / hscb_pkg::TICK_NS)
) (
   // clock and reset
   input  wire logic                                  sys_clk,
   input  wire logic                                  rst_n,
   // field inputs
   input  wire logic [hscb_pkg::NCH-1:0]              pinIn,
   input  wire logic                                  activeLow,
   input  wire logic                                  scanPulse,
   // channel configuration
   input  wire hscb_pkg::hscb_cfg_t [hscb_pkg::NCH-1:0] chanCfg,
   // results
   output logic [hscb_pkg::NCH-1:0][hscb_pkg::CNT_W-1:0] countOut,
   output logic [hscb_pkg::NCH-1:0]              discrete_input_image_bit,
   output logic                                  markerReject
);
   localparam int NCH = hscb_pkg::NCH;
   localparam int CW  = hscb_pkg::CNT_W;
   localparam logic [CW-1:0] ONE = hscb_pkg::ONE;

   hscb_pkg::hscb_state_t       st_q;
   hscb_pkg::hscb_state_t       st_d;
   hscb_pkg::hscb_pin_t [NCH-1:0] pc;
   logic                        tick;
   logic [hscb_pkg::NGATE-1:0]  gate;
   logic                        markOn;
   logic                        markFire;

   for (genvar i = 0; i < NCH; i++) begin : g_pin
      hscb_pin_cond u_pin (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .pinRaw    (pinIn[i]),
         .activeLow (activeLow),
         .pin       (pc[i])
      );
   end

   hscb_timebase #(
      .TICK_CYC (hscb_pkg::TICK_CYC),
      .G0_TICKS (G0_TICKS),
      .G1_TICKS (G1_TICKS),
      .G2_TICKS (G2_TICKS)
   ) u_tb (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tick    (tick),
      .gate    (gate)
   );

   // limit compare uses >= so a limit lowered under the count still wraps
   function automatic logic [CW-1:0] stepUp(input logic [CW-1:0] v,
      input logic [hscb_pkg::CPR_W-1:0] lim);
      logic [CW-1:0] n;
      n = v + ONE;
      if (lim != '0 && n >= CW'(lim)) begin
         n = '0;
      end
      return n;
   endfunction

   function automatic logic [CW-1:0] stepDn(input logic [CW-1:0] v,
      input logic [hscb_pkg::CPR_W-1:0] lim);
      logic [CW-1:0] n;
      n = v - ONE;
      if (v == '0) begin
         n = (lim != '0) ? CW'(lim) - ONE : '1;
      end
      return n;
   endfunction

   // marker detection on channel three against the channel one phases
   always_comb begin
      hscb_pkg::hscb_mkmode_t m;
      hscb_pkg::hscb_pin_t    ph;
      logic                   asyncHit;
      m  = hscb_pkg::hscb_mkmode_t'(chanCfg[hscb_pkg::MARK_CH].mode);
      ph = (m.qual == hscb_pkg::MK_Q_PH1) ? pc[hscb_pkg::QUAD_CH]
                                          : pc[hscb_pkg::QUAD_CH + 1];
      markOn = chanCfg[hscb_pkg::MARK_CH].kind == hscb_pkg::TY_MARK
            && chanCfg[hscb_pkg::QUAD_CH].kind == hscb_pkg::TY_QUAD;
      asyncHit = 1'b0;
      if ({m.phFall, m.lvlHigh} == hscb_pkg::MK_RISE) begin
         asyncHit = pc[hscb_pkg::MARK_CH].rise;
      end else if ({m.phFall, m.lvlHigh} == hscb_pkg::MK_FALL) begin
         asyncHit = pc[hscb_pkg::MARK_CH].fall;
      end else if ({m.phFall, m.lvlHigh} == hscb_pkg::MK_BOTH) begin
         asyncHit = pc[hscb_pkg::MARK_CH].rise | pc[hscb_pkg::MARK_CH].fall;
      end
      markFire = 1'b0;
      if (m.qual == hscb_pkg::MK_Q_NONE) begin
         markFire = asyncHit;
      end else if (m.qual == hscb_pkg::MK_Q_PH1
                || m.qual == hscb_pkg::MK_Q_PH2) begin
         markFire = (pc[hscb_pkg::MARK_CH].level == m.lvlHigh)
                 && (m.phFall ? ph.fall : ph.rise);
      end
      markFire = markFire & markOn;
   end

   always_comb begin
      hscb_pkg::hscb_type_t k;
      logic [hscb_pkg::MODE_W-1:0] md;
      logic gs;
      logic startE;
      logic stopE;
      logic up;
      k      = hscb_pkg::TY_OFF;
      md     = '0;
      gs     = 1'b0;
      startE = 1'b0;
      stopE  = 1'b0;
      up     = 1'b0;
      st_d   = st_q;
      st_d.markRej = chanCfg[hscb_pkg::MARK_CH].kind == hscb_pkg::TY_MARK
                     && !markOn;
      for (int c = 0; c < NCH; c++) begin
         k  = chanCfg[c].kind;
         md = chanCfg[c].mode;
         // rejected or misplaced marker falls back to a plain input
         if (k == hscb_pkg::TY_MARK && !(c == hscb_pkg::MARK_CH && markOn)) begin
            k = hscb_pkg::TY_OFF;
         end
         st_d.img[c] = (k == hscb_pkg::TY_OFF) ? pc[c].level : 1'b0;
         if (k != hscb_pkg::TY_PULSE) begin
            st_d.ps[c] = hscb_pkg::PS_ARM;
         end
         case (k)
            hscb_pkg::TY_FREQ: begin
               gs = scanPulse;
               if (md == hscb_pkg::FRQ_1S) begin
                  gs = gate[0];
               end else if (md == hscb_pkg::FRQ_100MS) begin
                  gs = gate[1];
               end else if (md == hscb_pkg::FRQ_10MS) begin
                  gs = gate[2];
               end
               // edge in the gate cycle lands in the closing window
               if (gs) begin
                  st_d.cnt[c] = pc[c].rise ? st_q.acc[c] + ONE
                                           : st_q.acc[c];
                  st_d.acc[c] = '0;
               end else if (pc[c].rise) begin
                  st_d.acc[c] = st_q.acc[c] + ONE;
               end
            end
            hscb_pkg::TY_TOTAL: begin
               st_d.acc[c] = '0;
               if (md == hscb_pkg::TOT_FALL ? pc[c].fall : pc[c].rise) begin
                  st_d.cnt[c] = stepUp(st_q.cnt[c], chanCfg[c].cpr);
               end
            end
            hscb_pkg::TY_PULSE: begin
               startE = pc[c].rise;
               stopE  = pc[c].fall;
               if (md == hscb_pkg::PUL_LOW) begin
                  startE = pc[c].fall;
                  stopE  = pc[c].rise;
               end else if (md == hscb_pkg::PUL_PRISE) begin
                  stopE  = pc[c].rise;
               end else if (md == hscb_pkg::PUL_PFALL) begin
                  startE = pc[c].fall;
               end
               case (st_q.ps[c])
                  hscb_pkg::PS_ARM: begin
                     if (startE) begin
                        st_d.acc[c] = '0;
                        st_d.ps[c]  = hscb_pkg::PS_RUN;
                     end
                  end
                  hscb_pkg::PS_RUN: begin
                     if (tick) begin
                        st_d.acc[c] = st_q.acc[c] + ONE;
                     end
                     if (stopE) begin
                        st_d.cnt[c] = st_q.acc[c];
                        if (md == hscb_pkg::PUL_PRISE
                            || md == hscb_pkg::PUL_PFALL) begin
                           st_d.acc[c] = '0;
                        end else begin
                           st_d.ps[c] = hscb_pkg::PS_ARM;
                        end
                     end
                  end
                  default: begin
                     st_d.ps[c] = hscb_pkg::PS_ARM;
                  end
               endcase
            end
            hscb_pkg::TY_QUAD: begin
               st_d.acc[c] = '0;
               // x1 decode on phase one rising, phase two low means 1 leads 2
               if (pc[c].rise) begin
                  up = !pc[c ^ 1].level;
                  if (md == hscb_pkg::QUAD_DN) begin
                     up = !up;
                  end
                  st_d.cnt[c] = up ? stepUp(st_q.cnt[c], chanCfg[c].cpr)
                                   : stepDn(st_q.cnt[c], chanCfg[c].cpr);
               end
            end
            default: begin
               st_d.cnt[c] = '0;
               st_d.acc[c] = '0;
            end
         endcase
      end
      if (markFire) begin
         st_d.cnt[hscb_pkg::QUAD_CH] = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_q <= hscb_pkg::ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign countOut                 = st_q.cnt;
   assign discrete_input_image_bit = st_q.img;
   assign markerReject             = st_q.markRej;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      AST_OFF_IMAGE: assert property (
         chanCfg[g].kind == hscb_pkg::TY_OFF |=>
            st_q.img[g] == $past(pc[g].level) && st_q.cnt[g] == '0)
         else $error("off channel image or count wrong");
      AST_POLARITY: assert property (
         chanCfg[g].kind == hscb_pkg::TY_OFF |=>
            st_q.img[g] == ($past(pinIn[g]) ^ $past(activeLow)))
         else $error("input polarity not applied");
      AST_FREQ_GATE: assert property (
         chanCfg[g].kind == hscb_pkg::TY_FREQ
         && chanCfg[g].mode == hscb_pkg::FRQ_SCAN && scanPulse && !pc[g].rise
         |=> st_q.cnt[g] == $past(st_q.acc[g]) && st_q.acc[g] == '0)
         else $error("frequency gate did not latch");
      AST_TOT_FALL: assert property (
         chanCfg[g].kind == hscb_pkg::TY_TOTAL && chanCfg[g].cpr == '0
         && chanCfg[g].mode == hscb_pkg::TOT_FALL && pc[g].fall
         |=> st_q.cnt[g] == $past(st_q.cnt[g]) + ONE)
         else $error("falling edge not totalized");
      AST_TOT_WRAP: assert property (
         chanCfg[g].kind == hscb_pkg::TY_TOTAL && chanCfg[g].cpr != '0
         && chanCfg[g].mode == hscb_pkg::TOT_RISE && pc[g].rise
         && st_q.cnt[g] + ONE == CW'(chanCfg[g].cpr) |=> st_q.cnt[g] == '0)
         else $error("count did not wrap at limit");
      AST_PULSE_TIME: assert property (
         chanCfg[g].kind == hscb_pkg::TY_PULSE
         && chanCfg[g].mode == hscb_pkg::PUL_HIGH
         && st_q.ps[g] == hscb_pkg::PS_RUN && tick && !pc[g].fall
         |=> st_q.acc[g] == $past(st_q.acc[g]) + ONE)
         else $error("pulse timer missed a tick");
      AST_PULSE_LATCH: assert property (
         chanCfg[g].kind == hscb_pkg::TY_PULSE
         && chanCfg[g].mode == hscb_pkg::PUL_HIGH
         && st_q.ps[g] == hscb_pkg::PS_RUN && pc[g].fall
         |=> st_q.cnt[g] == $past(st_q.acc[g])
             && st_q.ps[g] == hscb_pkg::PS_ARM)
         else $error("pulse width not latched");
      AST_QUAD_DIR: assert property (
         chanCfg[g].kind == hscb_pkg::TY_QUAD && chanCfg[g].cpr == '0
         && chanCfg[g].mode == hscb_pkg::QUAD_DN && pc[g].rise
         && !pc[g ^ 1].level && !(g == hscb_pkg::QUAD_CH && markFire)
         |=> st_q.cnt[g] == $past(st_q.cnt[g]) - ONE)
         else $error("quadrature direction wrong");
   end

   AST_MARK_REJECT: assert property (
      chanCfg[hscb_pkg::MARK_CH].kind == hscb_pkg::TY_MARK
      && chanCfg[hscb_pkg::QUAD_CH].kind != hscb_pkg::TY_QUAD
      |=> markerReject && !$past(markFire))
      else $error("illegal marker not rejected");
   AST_MARK_CLEAR: assert property (
      markFire |=> st_q.cnt[hscb_pkg::QUAD_CH] == '0)
      else $error("marker did not clear count");

   CV_FREQ: cover property (chanCfg[0].kind == hscb_pkg::TY_FREQ
      && gate[0] ##1 st_q.cnt[0] != '0);
   CV_PULSE: cover property (st_q.ps[1] == hscb_pkg::PS_RUN
      ##[1:100] st_q.ps[1] == hscb_pkg::PS_ARM);
   CV_MARK: cover property (markFire);
   CV_REJECT: cover property (markerReject);
endmodule

// *** verification/hscb_field_src.sv ***
// field side model: plain pulse sources and a quadrature encoder
`timescale 1ns/1ps
module hscb_field_src (
   // clock
   input  wire logic       sys_clk,
   // bench requests
   input  wire logic [3:0] lvlReq,
   input  wire logic       quadOn,
   input  wire logic       stepReq,
   input  wire logic       stepDn,
   input  wire logic [1:0] slow,
   // field pins and busy flag
   output logic [3:0]      pinOut = 4'h0,
   output logic            busy
);
   logic [1:0] pos_q  = 2'h0;
   logic [1:0] wait_q = 2'h0;
   logic [2:0] left_q = 3'h0;
   logic       dn_q   = 1'b0;
   // one request is a full encoder cycle, so it ends back at rest
   assign busy = left_q != 3'h0;
   always_ff @(posedge sys_clk) begin
      if (stepReq && !busy) begin
         left_q <= 3'h4;
         dn_q   <= stepDn;
         wait_q <= slow;
      end else if (busy && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (busy) begin
         pos_q  <= dn_q ? pos_q - 2'h1 : pos_q + 2'h1;
         left_q <= left_q - 3'h1;
         wait_q <= slow;
      end
      // forward order 00,10,11,01: phase one leads phase two
      pinOut[1:0] <= quadOn ? {pos_q[1], pos_q[1] ^ pos_q[0]}
                            : lvlReq[1:0];
      pinOut[3:2] <= lvlReq[3:2];
   end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the fast pulse counter bank
`timescale 1ns/1ps
module testbench;
   localparam int G0 = 8;
   localparam int G1 = 4;
   localparam int G2 = 2;
   logic                      sys_clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic [3:0]                lvlReq = 4'h0;
   logic                      quadOn = 1'b0;
   logic                      stepReq = 1'b0;
   logic                      stepDn = 1'b0;
   logic [1:0]                slow = 2'h0;
   logic                      activeLow = 1'b0;
   logic                      scanPulse = 1'b0;
   hscb_pkg::hscb_cfg_t [3:0] chanCfg = '0;
   logic [3:0][31:0]          countOut;
   logic [3:0]                img;
   logic                      markerReject;
   logic [3:0]                pinIn;
   logic                      busy;
   int                        bad_count = 0;
   int                        cmp_count = 0;
   integer                    seed = 37638;

   initial forever #25 sys_clk = ~sys_clk;

   hscb_field_src src_u (
      .sys_clk (sys_clk),
      .lvlReq  (lvlReq),
      .quadOn  (quadOn),
      .stepReq (stepReq),
      .stepDn  (stepDn),
      .slow    (slow),
      .pinOut  (pinIn),
      .busy    (busy)
   );

   hscb_counter_bank #(
      .G0_TICKS (G0),
      .G1_TICKS (G1),
      .G2_TICKS (G2)
   ) dut_u (
      .sys_clk                  (sys_clk),
      .rst_n                    (rst_n),
      .pinIn                    (pinIn),
      .activeLow                (activeLow),
      .scanPulse                (scanPulse),
      .chanCfg                  (chanCfg),
      .countOut                 (countOut),
      .discrete_input_image_bit (img),
      .markerReject             (markerReject)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic setCfg(input int ch, input hscb_pkg::hscb_type_t k,
                         input logic [3:0] m, input logic [27:0] c);
      chanCfg[ch] <= '{kind: k, mode: m, cpr: c};
      cyc(2);
   endtask

   task automatic toggle(input int ch, input int hold);
      lvlReq[ch] <= ~lvlReq[ch];
      cyc(hold);
   endtask

   task automatic scan();
      scanPulse <= 1'b1;
      cyc(1);
      scanPulse <= 1'b0;
   endtask

   // random pacing makes the encoder answer promptly or slowly
   task automatic qstep(input logic dn);
      int k;
      stepReq <= 1'b1;
      stepDn  <= dn;
      slow    <= 2'($random(seed));
      cyc(1);
      stepReq <= 1'b0;
      cyc(1);
      for (k = 0; busy && k < 60; k++) cyc(1);
      if (k >= 60) bad_count++;
   endtask

   function automatic logic [31:0] stepv(input logic [31:0] v,
         input logic dn, input logic [27:0] c);
      if (dn) begin
         if (v != 32'h0) return v - 32'h1;
         return (c == 28'h0) ? 32'hFFFFFFFF : {4'h0, c} - 32'h1;
      end
      if (c != 28'h0 && v + 32'h1 >= {4'h0, c}) return 32'h0;
      return v + 32'h1;
   endfunction

   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      bad_count++;
      test_done();
   end

   initial begin
      int          n;
      logic [31:0] e;
      logic [27:0] c;
      logic [3:0]  m;
      cyc(20);
      check(countOut[0] | countOut[1] | countOut[2] | countOut[3],
            32'h0);
      check({27'h0, img, markerReject}, 32'h0);
      rst_n <= 1'b1;
      cyc(2);
      for (int i = 0; i < 8; i++) begin
         m = 4'($random(seed));
         activeLow <= i[0];
         lvlReq <= m;
         cyc(4);
         check({28'h0, img}, {28'h0, m ^ {4{i[0]}}});
         check(countOut[i % 4], 32'h0);
      end
      activeLow <= 1'b0;
      lvlReq <= 4'h0;
      cyc(4);
      $display("image test done");
      for (int i = 0; i < 8; i++) begin
         // first two passes force a wrap on every rise and a free count
         c = (i == 0) ? 28'h1 : (i == 1) ? 28'h0
           : (i % 4 == 3) ? 28'hFFFFFFF : 28'({$random(seed)} % 5);
         m = i[0] ? hscb_pkg::TOT_FALL : hscb_pkg::TOT_RISE;
         n = {$random(seed)} % 9;
         setCfg(3, hscb_pkg::TY_TOTAL, m, c);
         // an odd toggle count leaves one more rise than fall
         for (int j = 0; j < 2 * n + 1; j++) toggle(3, 2 + j % 3);
         cyc(3);
         e = 32'h0;
         for (int j = 0; j < n + 1 - i[0]; j++) e = stepv(e, 1'b0, c);
         check(countOut[3], e);
         check({31'h0, img[3]}, 32'h0);
         setCfg(3, hscb_pkg::TY_OFF, 4'h0, 28'h0);
         toggle(3, 3);
      end
      $display("totalize test done");
      for (int i = 0; i < 3; i++) begin
         setCfg(1, hscb_pkg::TY_FREQ, 4'(i), 28'h3);
         for (int j = 0; j < 100; j++) toggle(1, 4);
         e = 32'((i == 0 ? G0 : i == 1 ? G1 : G2) * 20 / 8);
         check(countOut[1], e);
      end
      setCfg(1, hscb_pkg::TY_FREQ, hscb_pkg::FRQ_SCAN, 28'h0);
      n = 1 + {$random(seed)} % 6;
      scan();
      for (int j = 0; j < 2 * n; j++) toggle(1, 3);
      scan();
      cyc(3);
      check(countOut[1], 32'(n));
      setCfg(1, hscb_pkg::TY_OFF, 4'h0, 28'h0);
      $display("frequency test done");
      for (int i = 0; i < 4; i++) begin
         setCfg(3, hscb_pkg::TY_PULSE, 4'(i), 28'h0);
         for (int j = 0; j < 4; j++) toggle(3, 200);
         e = (i < 2) ? 32'hA : 32'h14;
         // tick phase against the edges may lose one tick
         check(32'(countOut[3] == e || countOut[3] == e - 32'h1),
               32'h1);
      end
      setCfg(3, hscb_pkg::TY_OFF, 4'h0, 28'h0);
      $display("pulse test done");
      quadOn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         // async rise, fall, both, then high level qualified by phase one
         m = (i == 3) ? {hscb_pkg::MK_Q_PH1, 2'b01} : {2'b00, 2'(i)};
         setCfg(2, hscb_pkg::TY_MARK, m, 28'h0);
         c = i[0] ? 28'h5 : 28'h0;
         setCfg(0, hscb_pkg::TY_QUAD, 4'(i[1]), c);
         e = 32'h0;
         for (int j = 0; j < 10; j++) begin
            n = {$random(seed)} % 2;
            qstep(n[0]);
            e = stepv(e, n[0] ^ i[1], c);
         end
         cyc(3);
         check(countOut[0], e);
         check({31'h0, markerReject}, 32'h0);
         lvlReq[2] <= 1'b1;
         cyc(4);
         // the qualified mode needs a phase one rise while the marker is high
         if (i == 3) qstep(1'b0);
         lvlReq[2] <= 1'b0;
         cyc(4);
         check(countOut[0], 32'h0);
         setCfg(0, hscb_pkg::TY_OFF, 4'h0, 28'h0);
         lvlReq[2] <= 1'b1;
         cyc(4);
         check({30'h0, markerReject, img[2]}, 32'h3);
         lvlReq[2] <= 1'b0;
         cyc(2);
      end
      $display("quadrature test done");
      test_done();
   end
endmodule
